// *** rtl/axl_exec.sv ***
// decode and execution of the auxiliary, page and shifted accumulator loads
// Overview of operation
// - aux target index from opcode bits 10..8
// - memory word or constant into target aux
// - 8-bit short or 16-bit long constant
// - constants zero-extended, no status bits change
// - long form: two words, index in low three
// - aux load 2 cycles, plus waits
// - shared single-access block adds one cycle
// - repeated aux load 2n plus nd
// - long constant 2, or 2+2p external
// - load beats post-modify of same register
// - shifted acc load 1, 1+d, 2+d+p
// - repeated shifted load n, n+1+p+nd
// - page load 9-bit constant in low bits
// - page load writes only page pointer field
// - direct address is page pointer plus offset
// - status word load also sets page pointer
// - program counter advances before the update
// - seven indirect pointer update options
// - shift by temp low four, extend by mode
`include "axl_defines.svh"

module axl_exec #(
	parameter logic [15:0] RESET_PC = `AXL_PC_RST
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// instruction issue
	input wire logic issue_valid,
	input wire axl_pkg::axl_issue_t issue,
	input wire axl_pkg::axl_place_t plc,
	// status word load
	input wire logic stw_valid,
	input wire logic [15:0] stw_data,
	// operand and shift sources
	input wire logic [15:0] mem_rd_data,
	input wire logic [15:0] temp_register,
	input wire logic sign_extend_mode,
	// aux register readback select
	input wire logic [2:0] aux_sel,
	// handshake and memory request
	output logic ready,
	output logic busy,
	output logic done,
	output logic mem_rd,
	output logic [15:0] mem_addr,
	// architectural state
	output logic [15:0] pc,
	output logic [15:0] status_word_zero,
	output logic [31:0] accumulator,
	output logic [15:0] aux_data
);
	axl_pkg::axl_state_t r;
	axl_pkg::axl_state_t next_r;
	logic accept;

	// opcode to instruction kind
	function automatic axl_pkg::axl_kind_t axl_decode(input logic [15:0] w);
		axl_pkg::axl_kind_t k;
		k = axl_pkg::AXL_NONE;
		if (w[15:11] == `AXL_OP_LAR_MEM) begin
			k = axl_pkg::AXL_LAR_MEM;
		end else if (w[15:11] == `AXL_OP_LAR_SK) begin
			k = axl_pkg::AXL_LAR_SK;
		end else if (w[15:3] == `AXL_OP_LAR_LK) begin
			k = axl_pkg::AXL_LAR_LK;
		end else if (w[15:8] == `AXL_OP_LDP_MEM) begin
			k = axl_pkg::AXL_LDP_MEM;
		end else if (w[15:9] == `AXL_OP_LDP_SK) begin
			k = axl_pkg::AXL_LDP_SK;
		end else if (w[15:8] == `AXL_OP_SHIFTED_ACC_LOAD_INSTRUCTION) begin
			k = axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION;
		end
		return k;
	endfunction : axl_decode

	// bit order reversal for reverse-carry updates
	function automatic logic [15:0] axl_rev(input logic [15:0] a);
		logic [15:0] o;
		o = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			o[i] = a[15 - i];
		end
		return o;
	endfunction : axl_rev

	// pointer post-modification
	function automatic logic [15:0] axl_post(input logic [15:0] a, input logic [15:0] x,
		input logic [2:0] aux_update_field);
		logic [15:0] o;
		o = a;
		case (aux_update_field)
			`AXL_ARU_DEC: o = a - 16'h0001;
			`AXL_ARU_INC: o = a + 16'h0001;
			`AXL_ARU_IDXDEC: o = a - x;
			`AXL_ARU_IDXINC: o = a + x;
			`AXL_ARU_BRDEC: o = axl_rev(axl_rev(a) - axl_rev(x));
			`AXL_ARU_BRINC: o = axl_rev(axl_rev(a) + axl_rev(x));
			default: o = a;
		endcase
		return o;
	endfunction : axl_post

	// left shift with sign or zero fill
	function automatic logic [31:0] axl_shift(input logic [15:0] d, input logic [3:0] s,
		input logic sx);
		logic [31:0] e;
		e = sx ? {{16{d[15]}}, d} : {16'h0000, d};
		return e << s;
	endfunction : axl_shift

	// cycles of every repetition but the first
	function automatic logic [7:0] axl_rep_len(input axl_pkg::axl_kind_t k,
		input axl_pkg::axl_place_t p);
		logic [7:0] b;
		b = (k == axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION) ? `AXL_BASE_SHIFTED_ACC_LOAD_INSTRUCTION : `AXL_BASE_LOAD;
		if (p.op_ext && k != axl_pkg::AXL_LAR_SK && k != axl_pkg::AXL_LAR_LK
			&& k != axl_pkg::AXL_LDP_SK) begin
			b = b + {4'h0, p.d_wait};
		end
		return b;
	endfunction : axl_rep_len

	// cycles of the first repetition, carrying conflict and code waits
	function automatic logic [7:0] axl_first_len(input axl_pkg::axl_kind_t k,
		input axl_pkg::axl_place_t p);
		logic [7:0] b;
		logic memop;
		memop = (k == axl_pkg::AXL_LAR_MEM || k == axl_pkg::AXL_LDP_MEM
			|| k == axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION);
		b = axl_rep_len(k, p);
		if (memop && p.same_single_access_ram && !p.op_ext && !p.code_ext) begin
			b = b + `AXL_CONFLICT;
		end
		if (p.code_ext) begin
			b = b + {4'h0, p.p_wait};
			if (k == axl_pkg::AXL_LAR_LK) begin
				b = b + {4'h0, p.p_wait};
			end
			if (memop && p.op_ext) begin
				b = b + 8'h01;
			end
		end
		return b;
	endfunction : axl_first_len

	// next state: writeback, sequencing and issue of one repetition
	always_comb begin
		axl_pkg::axl_kind_t k;
		logic issue_now;
		logic [15:0] op;
		logic [2:0] ptr;
		k = axl_decode(issue.word);
		issue_now = 1'b0;
		op = 16'h0000;
		ptr = 3'h0;
		accept = 1'b0;
		next_r = r;
		next_r.done = 1'b0;
		next_r.mem_rd = 1'b0;
		next_r.issued = 1'b0;
		next_r.aux_data = r.ar[aux_sel];
		// writeback of the repetition issued last cycle
		if (r.issued) begin
			op = r.mem_rd ? mem_rd_data : r.imm;
			case (r.kind)
				axl_pkg::AXL_LAR_MEM, axl_pkg::AXL_LAR_SK, axl_pkg::AXL_LAR_LK: begin
					next_r.ar[r.tgt] = op;
				end
				axl_pkg::AXL_LDP_MEM, axl_pkg::AXL_LDP_SK: begin
					next_r.st0[`AXL_DP_MSB:0] = op[`AXL_DP_MSB:0];
				end
				axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION: begin
					next_r.acc = axl_shift(op, temp_register[3:0], sign_extend_mode);
				end
				default: begin
					next_r.acc = r.acc;
				end
			endcase
			next_r.done = r.last;
		end
		// sequencing
		case (r.fsm)
			axl_pkg::AXL_IDLE: begin
				if (issue_valid && r.ready && k != axl_pkg::AXL_NONE) begin
					accept = 1'b1;
					next_r.kind = k;
					next_r.word = issue.word;
					// pc first, the register update comes later
					next_r.pc = r.pc + ((k == axl_pkg::AXL_LAR_LK) ? 16'h0002 : 16'h0001);
					next_r.tgt = (k == axl_pkg::AXL_LAR_LK) ? issue.word[2:0] : issue.word[10:8];
					case (k)
						axl_pkg::AXL_LAR_SK: next_r.imm = {8'h00, issue.word[7:0]};
						axl_pkg::AXL_LAR_LK: next_r.imm = issue.lk;
						axl_pkg::AXL_LDP_SK: next_r.imm = {7'h00, issue.word[8:0]};
						default: next_r.imm = 16'h0000;
					endcase
					if (k == axl_pkg::AXL_LAR_MEM || k == axl_pkg::AXL_LDP_MEM
						|| k == axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION) begin
						next_r.reps = (issue.rpt_n == 8'h00) ? 8'h01 : issue.rpt_n;
					end else begin
						next_r.reps = 8'h01;
					end
					next_r.rep_len = axl_rep_len(k, plc);
					next_r.cnt = axl_first_len(k, plc) - 8'h01;
					next_r.fsm = axl_pkg::AXL_EXEC;
					issue_now = 1'b1;
				end else if (stw_valid && r.ready && !issue_valid) begin
					next_r.st0 = stw_data;
				end
			end
			axl_pkg::AXL_EXEC: begin
				if (r.cnt != 8'h00) begin
					next_r.cnt = r.cnt - 8'h01;
				end else if (r.reps != 8'h00) begin
					next_r.cnt = r.rep_len - 8'h01;
					issue_now = 1'b1;
				end else begin
					next_r.fsm = axl_pkg::AXL_IDLE;
				end
			end
			default: begin
				next_r.fsm = axl_pkg::AXL_IDLE;
			end
		endcase
		// issue one repetition: operand address and pointer update
		if (issue_now) begin
			next_r.reps = next_r.reps - 8'h01;
			next_r.last = (next_r.reps == 8'h00);
			next_r.issued = 1'b1;
			ptr = next_r.st0[`AXL_ARP_LSB +: 3];
			if (next_r.kind == axl_pkg::AXL_LAR_MEM || next_r.kind == axl_pkg::AXL_LDP_MEM
				|| next_r.kind == axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION) begin
				next_r.mem_rd = 1'b1;
				if (next_r.word[`AXL_MODE_BIT]) begin
					next_r.mem_addr = next_r.ar[ptr];
					if (!(next_r.kind == axl_pkg::AXL_LAR_MEM && next_r.tgt == ptr)) begin
						next_r.ar[ptr] = axl_post(next_r.ar[ptr], next_r.ar[0],
							next_r.word[6:4]);
					end
					if (next_r.word[`AXL_NBIT]) begin
						next_r.st0[`AXL_ARP_LSB +: 3] = next_r.word[2:0];
					end
				end else begin
					next_r.mem_addr = {next_r.st0[`AXL_DP_MSB:0], next_r.word[6:0]};
				end
			end
		end
		next_r.busy = (next_r.fsm == axl_pkg::AXL_EXEC);
		next_r.ready = !next_r.busy && !next_r.issued;
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '0;
			r.fsm <= axl_pkg::AXL_IDLE;
			r.pc <= RESET_PC;
			r.st0 <= `AXL_ST0_RST;
			r.kind <= axl_pkg::AXL_NONE;
			r.ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the state register
	assign ready = r.ready;
	assign busy = r.busy;
	assign done = r.done;
	assign mem_rd = r.mem_rd;
	assign mem_addr = r.mem_addr;
	assign pc = r.pc;
	assign status_word_zero = r.st0;
	assign accumulator = r.acc;
	assign aux_data = r.aux_data;

	// helper: busy length and snapshot of the accepted instruction
	logic [9:0] h_blen;
	axl_pkg::axl_kind_t h_kind;
	axl_pkg::axl_place_t h_plc;
	logic [7:0] h_n;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			h_blen <= 10'h000;
			h_kind <= axl_pkg::AXL_NONE;
			h_plc <= '0;
			h_n <= 8'h00;
		end else if (accept) begin
			h_blen <= 10'h000;
			h_kind <= axl_decode(issue.word);
			h_plc <= plc;
			h_n <= (issue.rpt_n == 8'h00) ? 8'h01 : issue.rpt_n;
		end else if (r.busy) begin
			h_blen <= h_blen + 10'h001;
		end
	end

	lar_int_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && k_is(axl_pkg::AXL_LAR_MEM) && issue.rpt_n <= 8'h01 && !plc.code_ext
		&& !plc.op_ext && !plc.same_single_access_ram |=> r.busy [*2] ##1 !r.busy)
		else $error("aux load from internal memory not two cycles");
	conflict_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && k_is(axl_pkg::AXL_LAR_MEM) && issue.rpt_n <= 8'h01 && !plc.code_ext
		&& !plc.op_ext && plc.same_single_access_ram |=> r.busy [*3] ##1 !r.busy)
		else $error("shared block conflict cycle missing");
	rpt_lar_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(r.busy) && h_kind == axl_pkg::AXL_LAR_MEM && !h_plc.code_ext
		&& !h_plc.same_single_access_ram |-> h_blen == 2 * h_n + (h_plc.op_ext ? h_n * h_plc.d_wait : 0))
		else $error("repeated aux load length wrong");
	lk_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(r.busy) && h_kind == axl_pkg::AXL_LAR_LK
		|-> h_blen == 2 + (h_plc.code_ext ? 2 * h_plc.p_wait : 0))
		else $error("long constant load length wrong");
	shifted_acc_load_instruction_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept && k_is(axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION) && issue.rpt_n <= 8'h01 && !plc.code_ext
		&& !plc.op_ext && !plc.same_single_access_ram |=> r.busy ##1 !r.busy)
		else $error("shifted load not one cycle");
	rpt_shifted_acc_load_instruction_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(r.busy) && h_kind == axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION && h_plc.code_ext && h_plc.op_ext
		|-> h_blen == h_n + 1 + h_plc.p_wait + h_n * h_plc.d_wait)
		else $error("repeated external shifted load length wrong");
	pc_first_a: assert property (@(posedge clk) disable iff (sys_rst)
		accept |=> r.pc == $past(r.pc) + (k_past_lk() ? 16'h0002 : 16'h0001) && !r.done)
		else $error("program counter not advanced at accept");
	page_only_a: assert property (@(posedge clk) disable iff (sys_rst)
		r.issued && r.kind == axl_pkg::AXL_LDP_SK |=> r.st0[8:0] == $past(r.word[8:0])
		&& r.st0[15:9] == $past(r.st0[15:9]))
		else $error("page load disturbed status word");
	short_zext_a: assert property (@(posedge clk) disable iff (sys_rst)
		r.issued && r.kind == axl_pkg::AXL_LAR_SK
		|=> r.ar[$past(r.word[10:8])] == {8'h00, $past(r.word[7:0])})
		else $error("short constant not zero extended");
	direct_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
		r.mem_rd && !r.word[7] |-> r.mem_addr == {r.st0[8:0], r.word[6:0]})
		else $error("direct address not page and offset");
	load_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
		r.issued && r.mem_rd && r.kind == axl_pkg::AXL_LAR_MEM
		|=> r.ar[$past(r.tgt)] == $past(mem_rd_data))
		else $error("loaded value lost to post modification");
	shift_load_a: assert property (@(posedge clk) disable iff (sys_rst)
		r.issued && r.kind == axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION |=> r.acc
		== axl_shift($past(mem_rd_data), $past(temp_register[3:0]), $past(sign_extend_mode)))
		else $error("shifted load value wrong");
	stw_take_a: assert property (@(posedge clk) disable iff (sys_rst)
		stw_valid && r.ready && !issue_valid |=> r.st0 == $past(stw_data))
		else $error("status word load not taken");

	lk_done_c: cover property (@(posedge clk) disable iff (sys_rst)
		r.done && r.kind == axl_pkg::AXL_LAR_LK);
	rpt_shifted_acc_load_instruction_c: cover property (@(posedge clk) disable iff (sys_rst)
		r.done && r.kind == axl_pkg::AXL_SHIFTED_ACC_LOAD_INSTRUCTION && h_n > 8'h02);
	ldp_ind_c: cover property (@(posedge clk) disable iff (sys_rst)
		r.done && r.kind == axl_pkg::AXL_LDP_MEM && r.word[7]);
	conflict_c: cover property (@(posedge clk) disable iff (sys_rst)
		r.issued && r.kind == axl_pkg::AXL_LAR_MEM && r.word[7]
		&& r.tgt == r.st0[15:13]);

	// kind test of the word offered this cycle
	function automatic logic k_is(input axl_pkg::axl_kind_t k);
		return axl_decode(issue.word) == k;
	endfunction : k_is

	// long form held in the accepted word
	function automatic logic k_past_lk();
		return r.kind == axl_pkg::AXL_LAR_LK;
	endfunction : k_past_lk
endmodule : axl_exec

// *** rtl/axl_defines.svh ***
// offsets, field positions, reset values, opcode patterns and cycle counts for the load unit
`ifndef AXL_DEFINES_SVH
`define AXL_DEFINES_SVH
// opcode patterns, compared against the upper opcode bits
`define AXL_OP_LAR_MEM 5'h00
`define AXL_OP_LAR_SK 5'h16
`define AXL_OP_LAR_LK 13'h17E1
`define AXL_OP_LDP_MEM 8'h0D
`define AXL_OP_LDP_SK 7'h5E
`define AXL_OP_SHIFTED_ACC_LOAD_INSTRUCTION 8'h6B
// opcode field positions
`define AXL_MODE_BIT 7
`define AXL_NBIT 3
// indirect update field codes
`define AXL_ARU_NONE 3'h0
`define AXL_ARU_DEC 3'h1
`define AXL_ARU_INC 3'h2
`define AXL_ARU_BRDEC 3'h4
`define AXL_ARU_IDXDEC 3'h5
`define AXL_ARU_IDXINC 3'h6
`define AXL_ARU_BRINC 3'h7
// status word zero field positions
`define AXL_DP_MSB 8
`define AXL_ARP_LSB 13
// reset values
`define AXL_ST0_RST 16'h0000
`define AXL_PC_RST 16'h0000
// cycle counts
`define AXL_BASE_LOAD 8'h02
`define AXL_BASE_SHIFTED_ACC_LOAD_INSTRUCTION 8'h01
`define AXL_CONFLICT 8'h01
`endif

// *** rtl/axl_pkg.sv ***
// types shared by the auxiliary and page load unit
package axl_pkg;
	typedef enum logic [0:0] {
		AXL_IDLE = 1'b0,
		AXL_EXEC = 1'b1
	} axl_fsm_t;

	typedef enum logic [2:0] {
		AXL_NONE = 3'b000,
		AXL_LAR_MEM = 3'b001,
		AXL_LAR_SK = 3'b010,
		AXL_LAR_LK = 3'b011,
		AXL_LDP_MEM = 3'b100,
		AXL_LDP_SK = 3'b101,
		AXL_SHIFTED_ACC_LOAD_INSTRUCTION = 3'b110
	} axl_kind_t;

	// one instruction handed to the unit
	typedef struct packed {
		logic [15:0] word;
		logic [15:0] lk;
		logic [7:0] rpt_n;
	} axl_issue_t;

	// where code and operand live, with their wait counts
	typedef struct packed {
		logic code_ext;
		logic op_ext;
		logic same_single_access_ram;
		logic [3:0] p_wait;
		logic [3:0] d_wait;
	} axl_place_t;

	typedef struct packed {
		axl_fsm_t fsm;
		logic [15:0] pc;
		logic [15:0] st0;
		logic [7:0][15:0] ar;
		logic [31:0] acc;
		axl_kind_t kind;
		logic [15:0] word;
		logic [15:0] imm;
		logic [2:0] tgt;
		logic [7:0] cnt;
		logic [7:0] reps;
		logic [7:0] rep_len;
		logic issued;
		logic last;
		logic mem_rd;
		logic [15:0] mem_addr;
		logic busy;
		logic ready;
		logic done;
		logic [15:0] aux_data;
	} axl_state_t;
endpackage : axl_pkg

// *** testbench/axl_mem_model.sv ***
// behavioural data memory that answers the load unit's reads
module axl_mem_model (
	// clock and read request
	input wire logic clk,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	// read data
	output logic [15:0] mem_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] churn = 16'h5A5A;
	// fixed content of every address
	function automatic logic [15:0] word_at(input logic [15:0] a);
		return ({a[7:0], a[15:8]} ^ 16'hB6E1) + a;
	endfunction : word_at
	// idle data wanders every cycle so a late sample never matches
	always_ff @(posedge clk) churn <= churn + 16'h3C5B;
	assign mem_rd_data = mem_rd ? word_at(mem_addr) : churn;
endmodule : axl_mem_model

// *** testbench/aux_and_page_load_exec_tb_top.sv ***
// self-checking bench for the auxiliary, page and shifted accumulator loads
`include "axl_defines.svh"

module aux_and_page_load_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		int len;
		logic [15:0] pc, st0, aux, addr;
		logic [31:0] acc;
		bit use_addr;
	} axl_note_t;
	// stimulus, all valued at time zero
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic issue_valid = 1'b0;
	logic stw_valid = 1'b0;
	logic sign_extend_mode = 1'b0;
	axl_pkg::axl_issue_t issue = '0;
	axl_pkg::axl_place_t plc = '0;
	logic [15:0] stw_data = 16'h0000;
	logic [15:0] temp_register = 16'h0000;
	logic [2:0] aux_sel = 3'h0;
	// outputs and bookkeeping
	logic ready, busy, done, mem_rd;
	logic [15:0] mem_rd_data, mem_addr, pc, status_word_zero, aux_data;
	logic [31:0] accumulator;
	int errors = 0;
	int checks = 0;
	axl_note_t notes[$];
	logic [15:0] e_pc = 16'h0000;
	logic [15:0] e_st0 = 16'h0000;
	logic [31:0] e_acc = 32'h0000_0000;
	logic [15:0] e_ar[8] = '{default: 16'h0000};

	// unit and the memory behind it
	axl_exec uut (
		.clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid), .issue(issue), .plc(plc),
		.stw_valid(stw_valid), .stw_data(stw_data), .mem_rd_data(mem_rd_data),
		.temp_register(temp_register), .sign_extend_mode(sign_extend_mode), .aux_sel(aux_sel),
		.ready(ready), .busy(busy), .done(done), .mem_rd(mem_rd), .mem_addr(mem_addr), .pc(pc),
		.status_word_zero(status_word_zero), .accumulator(accumulator), .aux_data(aux_data)
	);
	axl_mem_model mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data));

	// 25 MHz clock
	initial begin
		forever #20 clk = ~clk;
	end

	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// verdict and end of run
	task automatic results();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	// operand shifted by the temp register, extended by the mode bit
	function automatic logic [31:0] acc_of(input logic [15:0] d, t, input logic s);
		return (s ? {{16{d[15]}}, d} : {16'h0000, d}) << t[3:0];
	endfunction : acc_of

	// pointer after its post-update; index register is aux 0
	function automatic logic [15:0] post_mod(input logic [2:0] u, input logic [15:0] a, x);
		logic [15:0] ra;
		logic [15:0] rx;
		ra = {<<{a}};
		rx = {<<{x}};
		case (u)
			3'h1: post_mod = a - 16'h0001;
			3'h2: post_mod = a + 16'h0001;
			3'h4: post_mod = {<<{16'(ra - rx)}};
			3'h5: post_mod = a - x;
			3'h6: post_mod = a + x;
			3'h7: post_mod = {<<{16'(ra + rx)}};
			default: post_mod = a;
		endcase
	endfunction : post_mod

	// offer one instruction, note the outcome, let it run out
	task automatic drive(input logic [15:0] w, lk, input logic [7:0] n,
			input axl_pkg::axl_place_t pl, input int len, input logic [2:0] sel,
			input bit ua, input logic [15:0] ad);
		notes.push_back(axl_note_t'{len, e_pc, e_st0, e_ar[sel], ad, e_acc, ua});
		aux_sel <= sel;
		plc <= pl;
		issue <= '{word: w, lk: lk, rpt_n: n};
		issue_valid <= 1'b1;
		@(posedge clk);
		issue_valid <= 1'b0;
		issue <= 40'({$urandom, $urandom});
		plc <= 11'($urandom);
		// three edges past ready so the watcher checks before the next note is queued
		repeat (len + 3) @(posedge clk);
	endtask : drive

	// status word load, checked two edges on
	task automatic stw_load(input logic [15:0] v);
		stw_valid <= 1'b1;
		stw_data <= v;
		e_st0 = v;
		@(posedge clk);
		stw_valid <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("status word", 32'(e_st0), 32'(status_word_zero));
		@(posedge clk);
	endtask : stw_load

	// one randomised direct or immediate load of a kind
	task automatic do_op(input int kind);
		logic [15:0] r, ad, d, t;
		logic [15:0] wt[6];
		logic [7:0] n;
		logic [2:0] tg;
		logic mf, s;
		axl_pkg::axl_place_t pl;
		int len;
		r = 16'($urandom);
		t = 16'($urandom);
		s = 1'($urandom);
		tg = 3'($urandom);
		pl = 11'($urandom);
		n = (kind == 4) ? 8'h01 : 8'(1 + $urandom % 3);
		ad = {e_st0[8:0], r[14:8]};
		d = mem.word_at(ad);
		mf = kind == 2 || kind == 4 || kind == 5;
		wt = '{{`AXL_OP_LAR_SK, tg, r[7:0]}, {`AXL_OP_LAR_LK, tg},
			{`AXL_OP_LAR_MEM, tg, 1'b0, r[14:8]}, {`AXL_OP_LDP_SK, r[8:0]},
			{`AXL_OP_LDP_MEM, 1'b0, r[14:8]}, {`AXL_OP_SHIFTED_ACC_LOAD_INSTRUCTION, 1'b0, r[14:8]}};
		case (kind)
			0: e_ar[tg] = {8'h00, r[7:0]};
			1: e_ar[tg] = r;
			2: e_ar[tg] = d;
			3: e_st0[8:0] = r[8:0];
			4: e_st0[8:0] = d[8:0];
			default: e_acc = acc_of(d, t, s);
		endcase
		e_pc = e_pc + (kind == 1 ? 16'h0002 : 16'h0001);
		len = ((kind == 2 || kind == 5) ? int'(n) : 1)
			* ((kind == 5 ? 1 : 2) + (mf && pl.op_ext ? int'(pl.d_wait) : 0));
		len += (mf && pl.same_single_access_ram && !pl.op_ext && !pl.code_ext) ? 1 : 0;
		len += pl.code_ext ? int'(pl.p_wait) * (kind == 1 ? 2 : 1) + int'(mf && pl.op_ext) : 0;
		temp_register <= t;
		sign_extend_mode <= s;
		drive(wt[kind], r, n, pl, len, tg, mf, ad);
	endtask : do_op

	// watcher: counts busy cycles and done pulses, then checks the oldest note
	initial begin
		int cnt;
		int dn;
		logic [15:0] la;
		axl_note_t nt;
		cnt = 0;
		dn = 0;
		la = 16'h0000;
		forever begin
			@(negedge clk);
			if (mem_rd === 1'b1) begin
				la = mem_addr;
			end
			if (busy === 1'b1 || cnt != 0) begin
				dn += int'(done === 1'b1);
			end
			if (busy === 1'b1) begin
				cnt++;
			end else if (cnt != 0) begin
				@(negedge clk);
				chk("notes", 32'h1, 32'(notes.size()));
				nt = notes.pop_front();
				chk("busy cycles", nt.len, cnt);
				chk("done pulses", 32'h1, dn);
				chk("ready", 32'h1, 32'(ready));
				chk("pc", 32'(nt.pc), 32'(pc));
				chk("status word", 32'(nt.st0), 32'(status_word_zero));
				chk("accumulator", nt.acc, accumulator);
				chk("aux register", 32'(nt.aux), 32'(aux_data));
				if (nt.use_addr) begin
					chk("read address", 32'(nt.addr), 32'(la));
				end
				cnt = 0;
				dn = 0;
			end
		end
	end

	// reset, then the load scenarios
	initial begin
		logic [15:0] ad;
		logic [15:0] w;
		void'($urandom(32'h105DED8D));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk("reset pc", 32'h0, 32'(pc));
		chk("reset status", 32'h0, 32'(status_word_zero));
		@(posedge clk);
		$display("test reset done");
		stw_load(16'($urandom));
		for (int k = 0; k < 6; k++) begin
			repeat (8) do_op(k);
			$display("test kind %0d done", k);
		end
		repeat (24) do_op(int'($urandom % 6));
		$display("test mixed done");
		// load through the pointer register into itself, then hop the pointer
		stw_load(16'h8006);
		e_ar[4] = 16'h0300;
		e_pc += 16'h0002;
		drive({`AXL_OP_LAR_LK, 3'h4}, 16'h0300, 8'h01, '0, 2, 3'h4, 1'b0, 16'h0000);
		e_ar[4] = mem.word_at(16'h0300);
		e_pc += 16'h0001;
		w = {`AXL_OP_LAR_MEM, 3'h4, 1'b1, `AXL_ARU_INC, 4'h0};
		drive(w, 16'h0000, 8'h01, '0, 2, 3'h4, 1'b1, 16'h0300);
		ad = e_ar[4];
		e_ar[2] = mem.word_at(ad);
		e_ar[4] = ad + 16'h0001;
		e_st0[15:13] = 3'h5;
		e_pc += 16'h0001;
		w = {`AXL_OP_LAR_MEM, 3'h2, 1'b1, `AXL_ARU_INC, 1'b1, 3'h5};
		drive(w, 16'h0000, 8'h01, '0, 2, 3'h2, 1'b1, ad);
		$display("test indirect done");
		// every pointer update code on aux 5
		for (int i = 0; i < 8; i++) begin
			ad = e_ar[5];
			e_acc = acc_of(mem.word_at(ad), temp_register, sign_extend_mode);
			e_ar[5] = post_mod(3'(i), ad, e_ar[0]);
			e_pc += 16'h0001;
			w = {`AXL_OP_SHIFTED_ACC_LOAD_INSTRUCTION, 1'b1, 3'(i), 4'h5};
			drive(w, 16'h0000, 8'h01, '0, 1, 3'h5, 1'b1, ad);
		end
		$display("test update codes done");
		results();
	end

	// hang guard well beyond the longest expected run
	initial begin
		repeat (50000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		results();
	end
endmodule : aux_and_page_load_exec_tb_top
